/* design/tbm_consts.vh */
`ifndef TBM_CONSTS_VH
`define TBM_CONSTS_VH

// register byte offsets
`define TBM_A_CTRL      8'h00
`define TBM_A_STAT      8'h04
`define TBM_A_IRQ       8'h08
`define TBM_A_MASK      8'h0C
`define TBM_A_ID        8'h10

// control fields
`define TBM_CTRL_EN     0
`define TBM_CTRL_BCAST  1
`define TBM_CTRL_RST    2'h3

// status fields, state code in [7:4]
`define TBM_ST_TXDONE   0
`define TBM_ST_TXACK    1
`define TBM_ST_RXINH    2
`define TBM_ST_PEND     3

// interrupt event bits
`define TBM_EV_CFM      0
`define TBM_EV_IND      1
`define TBM_EV_RXERR    2
`define TBM_EV_NAK      3
`define TBM_EV_W        4

// frame identifier codes
`define TBM_FID_PAC     8'h01
`define TBM_FID_ENQ     8'h02
`define TBM_FID_ACK     8'h03
`define TBM_FID_NAK     8'h04

// packet header length in bytes
`define TBM_HDR_LEN     9'd6

// timing
`define TBM_CLK_NS      10
`define TBM_RESP_NS     2000
`define TBM_TURN_NS     500
`define TBM_RESP_CYC    (`TBM_RESP_NS / `TBM_CLK_NS)
`define TBM_TURN_CYC    ((`TBM_TURN_NS + `TBM_CLK_NS - 1) / `TBM_CLK_NS)

`endif

/* design/tbm_sym_tx.v */
`default_nettype none

module tbm_sym_tx (
  input  wire       clk,
  input  wire       nrst,
  input  wire [7:0] byte_data,
  input  wire       byte_valid,
  output wire       byte_ready,
  output wire       phy_req,
  output wire       phy_sym,
  input  wire       phy_cfm,
  output wire       tx_idle
);
  reg       busy_ff;
  reg [7:0] sh_ff;
  reg [2:0] cnt_ff;
  wire      last;

  // last symbol of a byte confirmed: next byte may load in the same edge
  assign last       = busy_ff & (cnt_ff == 3'h7) & phy_cfm;
  assign byte_ready = ~busy_ff | last;
  assign phy_req    = busy_ff;
  assign phy_sym    = sh_ff[0];
  assign tx_idle    = ~busy_ff;

  // one symbol at a time, advance only on confirmation
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_ff <= 1'b0;
      sh_ff   <= 8'h00;
      cnt_ff  <= 3'h0;
    end else if (byte_valid && byte_ready) begin
      busy_ff <= 1'b1;
      sh_ff   <= byte_data;
      cnt_ff  <= 3'h0;
    end else if (last) begin
      busy_ff <= 1'b0;
    end else if (busy_ff && phy_cfm) begin
      sh_ff   <= {1'b0, sh_ff[7:1]};
      cnt_ff  <= cnt_ff + 3'h1;
    end
  end
endmodule

`default_nettype wire

/* design/tbm_mac_core.v */
`include "tbm_consts.vh"
`default_nettype none

module tbm_mac_core #(
  parameter [15:0] RESP_CYC = `TBM_RESP_CYC,
  parameter [15:0] TURN_CYC = `TBM_TURN_CYC
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  output wire        irq,
  input  wire        user_send_request,
  output wire        user_send_ready,
  input  wire [7:0]  req_system_code,
  input  wire [7:0]  req_dest_id,
  input  wire [7:0]  req_length,
  input  wire [7:0]  user_tx_data,
  input  wire        user_tx_valid,
  output wire        user_tx_ready,
  input  wire        user_abort,
  output wire        user_send_confirmation,
  output wire        confirm_ok,
  output wire        user_receive_indication,
  output wire [7:0]  ind_system_code,
  output wire [7:0]  ind_dest_id,
  output wire [7:0]  ind_source_id,
  input  wire        token_rx,
  output wire        token_pass,
  input  wire        rx_active,
  input  wire        reply_ack,
  input  wire        reply_nak,
  input  wire        reply_bad,
  input  wire        rx_enquiry,
  input  wire        finish_packet_rx_state_done,
  input  wire        rx_frame_err,
  input  wire        rx_fcs_err,
  input  wire        rx_did_mismatch,
  input  wire [7:0]  rx_system_code,
  input  wire [7:0]  rx_dest_id,
  input  wire [7:0]  rx_source_id,
  output wire        phy_req,
  output wire        phy_sym,
  input  wire        phy_cfm
);
  // single state machine instance serves one user and one PHY
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_ENQ_TX = 4'h1;
  localparam [3:0] S_ENQ_WT = 4'h2;
  localparam [3:0] S_PAC_TX = 4'h3;
  localparam [3:0] S_PAC_WT = 4'h4; // await_packet_reply_state
  localparam [3:0] S_RX_FIN = 4'h5; // finish_packet_rx_state
  localparam [3:0] S_TURN = 4'h6;
  localparam [3:0] S_REPLY = 4'h7;  // send_packet_reply_state

  reg [3:0]  state_ff;
  reg [1:0]  ctrl_ff;
  reg [7:0]  id_ff;
  reg [3:0]  irq_stat_ff;
  reg [3:0]  irq_mask_ff;
  reg        tx_done_flag;
  reg        tx_acked_flag;
  reg        rx_inhibit_flag;
  reg [7:0]  sc_ff;
  reg [7:0]  dest_ff;
  reg [7:0]  len_ff;
  reg [8:0]  idx_ff;
  reg [15:0] response_timer;
  reg [15:0] turnaround_timer;
  reg        reply_ack_ff;
  reg        cfm_ff;
  reg        cfm_ok_ff;
  reg        ind_ff;
  reg        pass_ff;
  reg [7:0]  isc_ff;
  reg [7:0]  idid_ff;
  reg [7:0]  isid_ff;
  reg        rerr_ff;
  reg        ap_wr_ff;
  reg        ap_sel_ff;
  reg [7:0]  ap_addr_ff;
  reg [31:0] hrdata_ff;
  reg [3:0]  nxt_state;
  reg [7:0]  byte_data;
  reg        byte_valid;
  wire       byte_ready;
  wire       tx_idle;
  wire       ap_take;
  wire       wr_ctrl;
  wire       wr_stat;
  wire       wr_irq;
  wire       wr_mask;
  wire       wr_id;
  wire [8:0] pac_total;
  wire       tx_last;
  wire       bcast_ok;
  wire       addr_ok;
  wire       rx_valid;
  wire [3:0] ev;

  // header byte for the current index: frame id, source, destination twice, length, then system code
  function [7:0] hdr_byte;
    input [8:0] idx;
    input [7:0] frame_id_field;
    input [7:0] source_id_field;
    input [7:0] dest_id_field;
    input [7:0] len;
    input [7:0] sc;
    begin
      case (idx)
        9'd0: hdr_byte = frame_id_field;
        9'd1: hdr_byte = source_id_field;
        9'd2: hdr_byte = dest_id_field;
        9'd3: hdr_byte = dest_id_field;
        9'd4: hdr_byte = len;
        default: hdr_byte = sc;
      endcase
    end
  endfunction

  // bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;
  assign ap_take   = hsel & hready & htrans[1];
  assign wr_ctrl   = ap_sel_ff & ap_wr_ff & (ap_addr_ff == `TBM_A_CTRL);
  assign wr_stat   = ap_sel_ff & ap_wr_ff & (ap_addr_ff == `TBM_A_STAT);
  assign wr_irq    = ap_sel_ff & ap_wr_ff & (ap_addr_ff == `TBM_A_IRQ);
  assign wr_mask   = ap_sel_ff & ap_wr_ff & (ap_addr_ff == `TBM_A_MASK);
  assign wr_id     = ap_sel_ff & ap_wr_ff & (ap_addr_ff == `TBM_A_ID);

  // address phase capture and registered read data
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ap_sel_ff  <= 1'b0;
      ap_wr_ff   <= 1'b0;
      ap_addr_ff <= 8'h00;
      hrdata_ff  <= 32'h0000_0000;
    end else begin
      ap_sel_ff  <= ap_take;
      ap_wr_ff   <= hwrite;
      ap_addr_ff <= {haddr[7:2], 2'b00};
      if (ap_take && !hwrite) begin
        case ({haddr[7:2], 2'b00})
          `TBM_A_CTRL: hrdata_ff <= {30'h0, ctrl_ff};
          `TBM_A_STAT: hrdata_ff <= {24'h0, state_ff, ~tx_done_flag,
                                     rx_inhibit_flag, tx_acked_flag, tx_done_flag};
          `TBM_A_IRQ:  hrdata_ff <= {28'h0, irq_stat_ff};
          `TBM_A_MASK: hrdata_ff <= {28'h0, irq_mask_ff};
          `TBM_A_ID:   hrdata_ff <= {24'h0, id_ff};
          default:     hrdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // software registers
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff     <= `TBM_CTRL_RST;
      irq_mask_ff <= 4'h0;
      id_ff       <= 8'h01;
    end else begin
      if (wr_ctrl)
        ctrl_ff <= hwdata[1:0];
      if (wr_mask)
        irq_mask_ff <= hwdata[3:0];
      if (wr_id)
        id_ff <= hwdata[7:0];
    end
  end

  // sticky events, set wins over write-one-to-clear
  assign ev = {(state_ff == S_ENQ_WT) & reply_nak, rerr_ff, ind_ff, cfm_ff};
  assign irq = |(irq_stat_ff & irq_mask_ff);
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      irq_stat_ff <= 4'h0;
    else
      irq_stat_ff <= (irq_stat_ff & ~(wr_irq ? hwdata[3:0] : 4'h0)) | ev;
  end

  assign pac_total = `TBM_HDR_LEN + {1'b0, len_ff};
  assign bcast_ok  = ctrl_ff[`TBM_CTRL_BCAST] & (rx_dest_id == 8'h00);
  assign addr_ok   = (rx_dest_id == id_ff) | bcast_ok;
  assign rx_valid  = ~(rx_frame_err | rx_fcs_err | rx_did_mismatch);
  // only offered in idle, where a request is actually taken
  assign user_send_ready = tx_done_flag & ctrl_ff[`TBM_CTRL_EN] & (state_ff == S_IDLE);
  assign user_tx_ready = (state_ff == S_PAC_TX) & (idx_ff >= `TBM_HDR_LEN)
                         & (idx_ff < pac_total) & byte_ready;
  assign tx_last = byte_valid & byte_ready;

  // byte source for the symbol sender
  always @* begin
    byte_valid = 1'b0;
    byte_data  = 8'h00;
    case (state_ff)
      S_ENQ_TX: begin
        byte_valid = idx_ff < 9'd3;
        byte_data  = (idx_ff == 9'd0) ? `TBM_FID_ENQ : dest_ff;
      end
      S_PAC_TX: begin
        if (idx_ff < `TBM_HDR_LEN) begin
          byte_valid = 1'b1;
          byte_data  = hdr_byte(idx_ff, `TBM_FID_PAC, id_ff, dest_ff, len_ff, sc_ff);
        end else if (idx_ff < pac_total) begin
          byte_valid = user_tx_valid;
          byte_data  = user_tx_data;
        end
      end
      S_REPLY: begin
        byte_valid = idx_ff == 9'd0;
        byte_data  = reply_ack_ff ? `TBM_FID_ACK : `TBM_FID_NAK;
      end
      default: begin
        byte_valid = 1'b0;
      end
    endcase
  end

  // next state
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        if (finish_packet_rx_state_done)
          nxt_state = S_RX_FIN;
        else if (rx_enquiry)
          nxt_state = S_TURN;
        else if (token_rx && !tx_done_flag && ctrl_ff[`TBM_CTRL_EN])
          nxt_state = (dest_ff == 8'h00) ? S_PAC_TX : S_ENQ_TX;
      end
      S_ENQ_TX:
        if (idx_ff == 9'd3 && tx_idle)
          nxt_state = S_ENQ_WT;
      S_ENQ_WT:
        if (reply_ack)
          nxt_state = S_PAC_TX;
        else if (reply_nak || reply_bad || (response_timer == 16'h0000 && !rx_active))
          nxt_state = S_IDLE;
      S_PAC_TX:
        if (idx_ff == pac_total && tx_idle)
          nxt_state = (dest_ff == 8'h00) ? S_IDLE : S_PAC_WT;
      S_PAC_WT:
        if (reply_ack || reply_nak || reply_bad ||
            (response_timer == 16'h0000 && !rx_active))
          nxt_state = S_IDLE;
      S_RX_FIN:
        nxt_state = (rx_valid && addr_ok && rx_dest_id != 8'h00) ? S_TURN : S_IDLE;
      S_TURN:
        if (turnaround_timer == 16'h0000)
          nxt_state = S_REPLY;
      S_REPLY:
        if (idx_ff == 9'd1 && tx_idle)
          nxt_state = S_IDLE;
      default:
        nxt_state = S_IDLE;
    endcase
  end

  // state, timers, flags and user strobes
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff         <= S_IDLE;
      idx_ff           <= 9'd0;
      response_timer   <= 16'h0000;
      turnaround_timer <= 16'h0000;
      tx_done_flag     <= 1'b1;
      tx_acked_flag    <= 1'b0;
      rx_inhibit_flag  <= 1'b0;
      reply_ack_ff     <= 1'b0;
      sc_ff            <= 8'h00;
      dest_ff          <= 8'h00;
      len_ff           <= 8'h00;
      cfm_ff           <= 1'b0;
      cfm_ok_ff        <= 1'b0;
      ind_ff           <= 1'b0;
      pass_ff          <= 1'b0;
      rerr_ff          <= 1'b0;
      isc_ff           <= 8'h00;
      idid_ff          <= 8'h00;
      isid_ff          <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      cfm_ff   <= 1'b0;
      ind_ff   <= 1'b0;
      pass_ff  <= 1'b0;
      rerr_ff  <= 1'b0;
      if (nxt_state != state_ff)
        idx_ff <= 9'd0;
      else if (tx_last)
        idx_ff <= idx_ff + 9'd1;
      if (state_ff != S_ENQ_WT && state_ff != S_PAC_WT)
        response_timer <= RESP_CYC;
      else if (response_timer != 16'h0000)
        response_timer <= response_timer - 16'h0001;
      if (state_ff != S_TURN)
        turnaround_timer <= TURN_CYC;
      else if (turnaround_timer != 16'h0000)
        turnaround_timer <= turnaround_timer - 16'h0001;
      // rx inhibit: hardware set wins over software write-one clear
      if (wr_stat && hwdata[`TBM_ST_RXINH])
        rx_inhibit_flag <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (user_send_request && user_send_ready) begin
            tx_done_flag  <= 1'b0;
            tx_acked_flag <= 1'b0;
            sc_ff         <= req_system_code;
            dest_ff       <= req_dest_id;
            len_ff        <= req_length;
          end else if (user_abort && !tx_done_flag) begin
            tx_done_flag <= 1'b1;
            cfm_ff       <= 1'b1;
            cfm_ok_ff    <= 1'b0;
          end
          if (rx_enquiry && !finish_packet_rx_state_done)
            reply_ack_ff <= ~rx_inhibit_flag;
          if (token_rx && (tx_done_flag || !ctrl_ff[`TBM_CTRL_EN]) && !finish_packet_rx_state_done
              && !rx_enquiry)
            pass_ff <= 1'b1;
          if (finish_packet_rx_state_done) begin
            isc_ff  <= rx_system_code;
            idid_ff <= rx_dest_id;
            isid_ff <= rx_source_id;
          end
        end
        S_ENQ_WT: begin
          if (reply_nak)
            pass_ff <= 1'b1;
          else if (!reply_ack && !reply_bad && response_timer == 16'h0000
                   && !rx_active) begin
            tx_done_flag <= 1'b1;
            cfm_ff       <= 1'b1;
            cfm_ok_ff    <= 1'b0;
            pass_ff      <= 1'b1;
          end
        end
        S_PAC_TX: begin
          if (nxt_state == S_IDLE) begin
            tx_done_flag <= 1'b1;
            cfm_ff       <= 1'b1;
            cfm_ok_ff    <= 1'b1;
            pass_ff      <= 1'b1;
          end
        end
        S_PAC_WT: begin
          if (nxt_state == S_IDLE) begin
            tx_done_flag  <= 1'b1;
            tx_acked_flag <= reply_ack;
            cfm_ff        <= 1'b1;
            cfm_ok_ff     <= reply_ack;
            pass_ff       <= 1'b1;
          end
        end
        S_RX_FIN: begin
          if (!rx_valid)
            rerr_ff <= 1'b1;
          else if (addr_ok) begin
            rx_inhibit_flag <= 1'b1;
            ind_ff          <= 1'b1;
            reply_ack_ff    <= 1'b1;
          end
        end
        default: begin
          pass_ff <= 1'b0;
        end
      endcase
    end
  end

  assign user_send_confirmation  = cfm_ff;
  assign confirm_ok              = cfm_ok_ff;
  assign user_receive_indication = ind_ff;
  assign ind_system_code         = isc_ff;
  assign ind_dest_id             = idid_ff;
  assign ind_source_id           = isid_ff;
  assign token_pass              = pass_ff;

  // symbol sender toward the PHY
  tbm_sym_tx u_sym (
    .clk        (clk),
    .nrst       (nrst),
    .byte_data  (byte_data),
    .byte_valid (byte_valid),
    .byte_ready (byte_ready),
    .phy_req    (phy_req),
    .phy_sym    (phy_sym),
    .phy_cfm    (phy_cfm),
    .tx_idle    (tx_idle)
  );
endmodule

`default_nettype wire

/* bench/tbm_mac_core_assertions.sv */
`default_nettype none
module tbm_mac_core_assertions (
  input wire logic clk,
  input wire logic nrst,
  input wire logic user_send_request,
  input wire logic user_send_ready,
  input wire logic user_send_confirmation,
  input wire logic confirm_ok,
  input wire logic user_receive_indication,
  input wire logic finish_packet_rx_state_done,
  input wire logic rx_frame_err,
  input wire logic rx_fcs_err,
  input wire logic rx_did_mismatch,
  input wire logic token_pass,
  input wire logic phy_req,
  input wire logic phy_sym,
  input wire logic phy_cfm
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // received packet outcome
  wire bad_rx = finish_packet_rx_state_done && (rx_frame_err || rx_fcs_err || rx_did_mismatch);
  wire good_rx = finish_packet_rx_state_done && !bad_rx;
  property p_cfm_once; user_send_confirmation |=> !user_send_confirmation; endproperty
  a_cfm_once: assert property (p_cfm_once) else $error("confirmation longer than one cycle");
  property p_cfm_token; user_send_confirmation && confirm_ok |-> token_pass; endproperty
  a_cfm_token: assert property (p_cfm_token) else $error("good confirm without token pass");
  property p_cfm_ready; user_send_confirmation |-> ##[1:2] user_send_ready; endproperty
  a_cfm_ready: assert property (p_cfm_ready) else $error("done flag not set after confirm");
  property p_req_taken; user_send_request && user_send_ready |=> !user_send_ready; endproperty
  a_req_taken: assert property (p_req_taken) else $error("request not held pending");
  property p_sym_hold; phy_req && !phy_cfm |=> phy_req && $stable(phy_sym); endproperty
  a_sym_hold: assert property (p_sym_hold) else $error("symbol changed before confirm");
  property p_ind_once; user_receive_indication |=> !user_receive_indication; endproperty
  a_ind_once: assert property (p_ind_once) else $error("indication longer than one cycle");
  property p_ind_cause; user_receive_indication |-> $past(good_rx, 1) || $past(good_rx, 2);
  endproperty
  a_ind_cause: assert property (p_ind_cause) else $error("indication without valid packet");
  property p_bad_rx; bad_rx |=> !user_receive_indication [*3]; endproperty
  a_bad_rx: assert property (p_bad_rx) else $error("bad packet delivered upward");
  property p_tok_once; token_pass |=> !token_pass; endproperty
  a_tok_once: assert property (p_tok_once) else $error("token pass longer than one cycle");
  property p_cfm_quiet; user_send_confirmation |-> !phy_req; endproperty
  a_cfm_quiet: assert property (p_cfm_quiet) else $error("confirm while still sending");
  c_ok: cover property (user_send_confirmation && confirm_ok);
  c_fail: cover property (user_send_confirmation && !confirm_ok);
  c_ind: cover property (user_receive_indication);
endmodule

bind tbm_mac_core tbm_mac_core_assertions chk_u (.*);
`default_nettype wire

/* bench/tbm_phy_model.sv */
`default_nettype none
module tbm_phy_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       phy_req,
  input  wire logic       phy_sym,
  input  wire logic [1:0] lag,
  output var  logic       phy_cfm,
  output var  logic [7:0] rx_byte [0:63],
  output var  int         rx_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] bit_n;
  logic [1:0] wait_n;
  logic [7:0] sh;
  // one confirm per offered symbol after lag cycles, bytes rebuilt lsb first
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phy_cfm <= 1'h0;
      bit_n <= 3'h0;
      wait_n <= 2'h0;
      rx_cnt <= 0;
    end else begin
      phy_cfm <= 1'h0;
      if (phy_req && !phy_cfm) begin
        if (wait_n < lag) begin
          wait_n <= wait_n + 2'h1;
        end else begin
          phy_cfm <= 1'h1;
          wait_n <= 2'h0;
          bit_n <= bit_n + 3'h1;
          sh <= {phy_sym, sh[7:1]};
          if (bit_n == 3'h7) begin
            rx_byte[rx_cnt[5:0]] <= {phy_sym, sh[7:1]};
            rx_cnt <= rx_cnt + 1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* bench/token_bus_mac_completion_tb_top.sv */
`include "tbm_consts.vh"
`default_nettype none
module token_bus_mac_completion_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic fe, ce, dm; logic [7:0] dst; logic ind, ack;} tbm_row_t;
  localparam tbm_row_t ROWS [0:4] = '{'{1, 0, 0, 8'h01, 0, 0}, '{0, 1, 0, 8'h01, 0, 0},
    '{0, 0, 1, 8'h01, 0, 0}, '{0, 0, 0, 8'h00, 1, 0}, '{0, 0, 0, 8'h01, 1, 1}};
  logic clk = 0, nrst = 0, hsel = 0, hwrite = 0, user_send_request = 0, user_tx_valid = 1;
  logic user_abort = 0, token_rx = 0, rx_active = 0, reply_ack = 0, reply_nak = 0;
  logic reply_bad = 0, rx_enquiry = 0, finish_packet_rx_state_done = 0, rx_frame_err = 0, rx_fcs_err = 0;
  logic rx_did_mismatch = 0, phy_cfm, cfm_ok, hreadyout, hresp, irq, user_send_ready;
  logic user_tx_ready, user_send_confirmation, confirm_ok, user_receive_indication;
  logic token_pass, phy_req, phy_sym;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0]  htrans = 0, lag = 0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  req_system_code = 0, req_dest_id = 0, req_length = 0, user_tx_data = 8'hA0;
  logic [7:0]  rx_system_code = 0, rx_dest_id = 0, rx_source_id = 0, nd = 8'hA0;
  logic [7:0]  ind_system_code, ind_dest_id, ind_source_id, rx_byte [0:63];
  logic [23:0] ind_f;
  wire         hready;
  int          rx_cnt, err_total = 0, checked = 0, cyc = 0, cfm_n = 0, tok_n = 0, ind_n = 0;
  int          base, n, t;
  assign hready = hreadyout;
  tbm_mac_core #(.RESP_CYC(16'h0010), .TURN_CYC(16'h0002)) dut_u (.*);
  tbm_phy_model phy_u (.*);
  initial begin
    forever #5 clk = ~clk;
  end
  // event counters, data source and run ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (user_send_confirmation === 1'h1) begin
      cfm_n <= cfm_n + 1;
      cfm_ok <= confirm_ok;
    end
    if (token_pass === 1'h1) tok_n <= tok_n + 1;
    if (user_receive_indication === 1'h1) begin
      ind_n <= ind_n + 1;
      ind_f <= {ind_system_code, ind_dest_id, ind_source_id};
    end
    if (user_tx_ready === 1'h1) user_tx_data <= user_tx_data + 8'h01;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic end_sim;
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'h1);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'h0, a, 32'h0);
    chk(q & m, e);
  endtask
  task automatic pulse(input int k);
    case (k)
      0: token_rx <= 1'h1;
      1: reply_ack <= 1'h1;
      2: reply_nak <= 1'h1;
      3: rx_enquiry <= 1'h1;
      4: user_abort <= 1'h1;
      default: user_send_request <= 1'h1;
    endcase
    @(posedge clk);
    {token_rx, reply_ack, reply_nak, rx_enquiry, user_abort, user_send_request} <= 6'h00;
    @(posedge clk);
  endtask
  task automatic send(input logic [7:0] dst, input logic [7:0] len);
    req_dest_id <= dst;
    req_length <= len;
    req_system_code <= 8'h5A;
    pulse(5);
    base = rx_cnt;
    n = cfm_n;
    t = tok_n;
  endtask
  task automatic wait_bytes(input int k);
    while (rx_cnt < k) @(posedge clk);
    // let the sender drain its last symbol and leave its send state (wait state, or idle after a broadcast)
    repeat (2) @(posedge clk);
  endtask
  task automatic chk_pac(input int at, input logic [7:0] dst, input logic [7:0] len);
    logic [7:0] e [0:7];
    e = '{`TBM_FID_PAC, 8'h01, dst, dst, len, 8'h5A, nd, nd + 8'h01};
    for (int i = 0; i < 6 + len; i++) chk(rx_byte[at + i], e[i]);
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'h1;
    rd(`TBM_A_CTRL, 32'hF, 32'h3);
    rd(`TBM_A_ID, 32'hFF, 32'h1);
    rd(`TBM_A_STAT, 32'hF, 32'h1);
    rd(`TBM_A_IRQ, 32'hF, 32'h0);
    rd(8'h40, 32'hFFFFFFFF, 32'h0);
    chk(user_send_ready, 1'h1);
    ahb(1'h1, `TBM_A_MASK, 32'hF);
    foreach (ROWS[i]) begin
      ahb(1'h1, `TBM_A_STAT, 32'h4);
      ahb(1'h1, `TBM_A_IRQ, 32'hF);
      base = rx_cnt;
      n = ind_n;
      {rx_frame_err, rx_fcs_err, rx_did_mismatch} <= {ROWS[i].fe, ROWS[i].ce, ROWS[i].dm};
      {rx_system_code, rx_dest_id, rx_source_id} <= {8'h3C, ROWS[i].dst, 8'h07};
      finish_packet_rx_state_done <= 1'h1;
      @(posedge clk);
      finish_packet_rx_state_done <= 1'h0;
      tick(40);
      chk(ind_n - n, ROWS[i].ind);
      chk(rx_cnt - base, ROWS[i].ack);
      if (ROWS[i].ack) chk(rx_byte[base], `TBM_FID_ACK);
      if (ROWS[i].ind) chk(ind_f, {8'h3C, ROWS[i].dst, 8'h07});
      rd(`TBM_A_STAT, 32'h4, {29'h0, ROWS[i].ind, 2'h0});
      rd(`TBM_A_IRQ, 32'h6, {29'h0, !ROWS[i].ind, ROWS[i].ind, 1'h0});
      chk(irq, 1'h1);
    end
    // broadcast reception switched off: packet to all is dropped
    ahb(1'h1, `TBM_A_CTRL, 32'h1);
    n = ind_n;
    rx_dest_id <= 8'h00;
    finish_packet_rx_state_done <= 1'h1;
    @(posedge clk);
    finish_packet_rx_state_done <= 1'h0;
    tick(5);
    chk(ind_n - n, 0);
    ahb(1'h1, `TBM_A_CTRL, 32'h3);
    ahb(1'h1, `TBM_A_MASK, 32'h0);
    tick(1);
    chk(irq, 1'h0);
    ahb(1'h1, `TBM_A_MASK, 32'hF);
    ahb(1'h1, `TBM_A_IRQ, 32'hF);
    tick(1);
    chk(irq, 1'h0);
    // enquiry answered by receive-inhibit state
    for (int k = 0; k < 2; k++) begin
      base = rx_cnt;
      pulse(3);
      tick(30);
      chk(rx_byte[base], k ? `TBM_FID_ACK : `TBM_FID_NAK);
      ahb(1'h1, `TBM_A_STAT, 32'h4);
    end
    // unicast: enquiry, packet, acknowledged
    send(8'h05, 8'h02);
    chk(user_send_ready, 1'h0);
    pulse(0);
    wait_bytes(base + 3);
    chk({rx_byte[base], rx_byte[base + 1], rx_byte[base + 2]}, {`TBM_FID_ENQ, 16'h0505});
    pulse(1);
    wait_bytes(base + 11);
    chk_pac(base + 3, 8'h05, 8'h02);
    nd = nd + 8'h02;
    pulse(1);
    tick(3);
    chk(cfm_n - n, 1);
    chk(tok_n - t, 1);
    chk(cfm_ok, 1'h1);
    rd(`TBM_A_STAT, 32'h3, 32'h3);
    // broadcast with a slow physical layer
    lag <= 2'h3;
    send(8'h00, 8'h01);
    rd(`TBM_A_STAT, 32'h2, 32'h0);
    pulse(0);
    wait_bytes(base + 7);
    tick(3);
    chk_pac(base, 8'h00, 8'h01);
    nd = nd + 8'h01;
    chk(cfm_n - n, 1);
    chk(cfm_ok, 1'h1);
    lag <= 2'h0;
    // packet reply never comes
    send(8'h05, 8'h01);
    pulse(0);
    wait_bytes(base + 3);
    pulse(1);
    wait_bytes(base + 10);
    tick(30);
    chk(cfm_n - n, 1);
    chk(tok_n - t, 1);
    chk(cfm_ok, 1'h0);
    rd(`TBM_A_STAT, 32'h3, 32'h1);
    // refused enquiry, retry at next token, then abort
    send(8'h07, 8'h01);
    pulse(0);
    wait_bytes(base + 3);
    pulse(2);
    tick(3);
    chk(cfm_n - n, 0);
    chk(tok_n - t, 1);
    rd(`TBM_A_STAT, 32'h9, 32'h8);
    pulse(0);
    wait_bytes(base + 6);
    chk(rx_byte[base + 3], `TBM_FID_ENQ);
    pulse(2);
    tick(3);
    pulse(4);
    tick(3);
    chk(cfm_n - n, 1);
    chk(cfm_ok, 1'h0);
    // station id write, then a reset in mid-run restores defaults
    ahb(1'h1, `TBM_A_ID, 32'h33);
    rd(`TBM_A_ID, 32'hFF, 32'h33);
    nrst <= 1'h0;
    tick(2);
    nrst <= 1'h1;
    rd(`TBM_A_ID, 32'hFF, 32'h1);
    rd(`TBM_A_STAT, 32'hF, 32'h1);
    rd(`TBM_A_MASK, 32'hF, 32'h0);
    chk(irq, 1'h0);
    end_sim();
  end
endmodule
`default_nettype wire
